// [verilog/valve_setpoint_processing.sv]
/*
  configuration store and set point path of a current loop valve positioner,
  an AHB-Lite slave with zero wait states.
  assumes analog input, pressure, travel and session start come from logic on hclk.
*/
// Implementation choices: the AHB-Lite interface to the registers and the address map.
// Operation
// - tag shown when session opens
// - 32 character message stored, read back
// - 16 character descriptor stored, read back
// - valve and instrument serials, 12 characters
// - date kept as month, day, year
// - polling address limited to 0..15
// - address change only when out of service
// - input unit mA or percent
// - zero sense selects input to travel direction
// - zero input gives 0% or 100%
// - pressure and display units psi, bar, kPa
// - hide pressure above 125% of maximum supply
// - eleven fixed tuning sets C to M
// - expert gains replace the fixed set
// - linear, equal percent, quick, custom curve
// - 21 points, set point -6.25..106.25%
// - custom curve linear after reset
// - set point filter, zero bypasses
// - opening rate limited, zero unlimited
// - closing rate limited, zero unlimited
// - zero integral gain disables integrator
// - integrator off inside dead zone
`timescale 1ns/10ps
module valve_setpoint_processing #(
  parameter int unsigned TICK_CYCLES = valve_pkg::TICK_CYCLES_DFLT
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // process inputs
  input wire logic session_start,
  input wire logic signed [15:0] ai_value,
  input wire logic signed [15:0] actual_travel,
  input wire logic [15:0] pressure,
  // outputs
  output logic [63:0] session_tag,
  output logic tag_valid,
  output logic [15:0] pressure_display,
  output logic pressure_shown,
  output valve_pkg::pres_unit_t pres_unit,
  output valve_pkg::pres_unit_t local_display_unit,
  output logic ai_pct_unit,
  output valve_pkg::gains_t gains,
  output logic [3:0] poll_addr,
  output logic signed [15:0] travel_target,
  output logic signed [31:0] integ_value,
  output logic integ_active
);
  import valve_pkg::*;

  function automatic logic is_curve(input logic [11:0] a);
    is_curve = (a >= OFF_CURVE) && (a < OFF_CURVE + 12'(4 * CURVE_PTS));
  endfunction

  function automatic logic [4:0] curve_idx(input logic [11:0] a);
    logic [11:0] d;
    d = a - OFF_CURVE;
    curve_idx = d[6:2];
  endfunction

  function automatic gains_t tune_gains(input logic [3:0] s);
    tune_gains.kp = KP_BASE + 16'(KP_STEP * s);
    tune_gains.kv = KV_BASE + 16'(KV_STEP * s);
    tune_gains.km = KM_BASE + 16'(KM_STEP * s);
  endfunction

  // bus front end: address phase captured, write done in the data phase
  ahb_req_t req_r;
  logic [31:0] hrdata_r;
  logic [31:0] rd_w;
  wire logic take = hsel & hready & htrans[1];
  wire logic [11:0] raddr = haddr[11:0];
  wire logic wr = req_r.valid & req_r.write;
  wire logic [11:0] wa = req_r.addr;

  logic [31:0] id_r [ID_WORDS];
  logic [23:0] date_r;
  logic [3:0] poll_r;
  logic oos_r;
  logic [8:0] units_r;
  logic signed [15:0] in_hi_r, in_lo_r;
  logic [15:0] max_sup_r;
  logic [3:0] tune_set_r;
  logic expert_r;
  gains_t expert_r_g;
  char_t char_r;
  logic [15:0] smooth_r, open_r, close_r, igain_r, idz_r;
  logic refused_r;
  logic signed [15:0] cv_sp [CURVE_PTS];
  logic signed [15:0] cv_tv [CURVE_PTS];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_r <= '0;
      hrdata_r <= 32'h0000_0000;
    end else begin
      req_r <= '{addr: raddr, write: hwrite, valid: take};
      hrdata_r <= (take && !hwrite) ? rd_w : 32'h0000_0000;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  // write side decode
  wire logic wr_id = wr && (wa < OFF_DATE);
  wire logic wr_poll = wr && (wa == OFF_POLL);
  wire logic poll_ok = oos_r && (hwdata <= 32'(POLL_MAX));
  wire logic wr_cv = wr && is_curve(wa);
  wire logic [4:0] wcv = curve_idx(wa);
  wire logic signed [15:0] wsp = hwdata[15:0];
  wire logic signed [15:0] wsp_cl = (wsp < SP_MIN) ? SP_MIN : (wsp > SP_MAX) ? SP_MAX : wsp;
  wire logic refuse_set = wr_poll && !poll_ok;
  wire logic refuse_clr = wr && (wa == OFF_STAT) && hwdata[STAT_REFUSED_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < ID_WORDS; i++) id_r[i] <= 32'h0000_0000;
    end else if (wr_id) begin
      id_r[wa[6:2]] <= hwdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      date_r <= 24'h00_0000;
      poll_r <= 4'h0;
      oos_r <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      if (wr && wa == OFF_DATE) date_r <= hwdata[23:0];
      if (wr_poll && poll_ok) poll_r <= hwdata[3:0];
      if (wr && wa == OFF_MODE) oos_r <= hwdata[0];
      refused_r <= refuse_set | (refused_r & ~refuse_clr);
    end
  end

  wire logic [1:0] wpres = hwdata[UNIT_PRES_LSB +: 2];
  wire logic [1:0] wdisp = hwdata[UNIT_DISP_LSB +: 2];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      units_r <= 9'h000;
      in_hi_r <= PCT_FULL;
      in_lo_r <= 16'sh0000;
      max_sup_r <= 16'hFFFF;
    end else if (wr && wa == OFF_UNITS) begin
      units_r[UNIT_AI_BIT] <= hwdata[UNIT_AI_BIT];
      if (wpres != 2'(PRES_NONE)) units_r[UNIT_PRES_LSB +: 2] <= wpres;
      if (wdisp != 2'(PRES_NONE)) units_r[UNIT_DISP_LSB +: 2] <= wdisp;
      units_r[UNIT_ZERO_BIT] <= hwdata[UNIT_ZERO_BIT];
    end else begin
      if (wr && wa == OFF_IN_HI) in_hi_r <= hwdata[15:0];
      if (wr && wa == OFF_IN_LO) in_lo_r <= hwdata[15:0];
      if (wr && wa == OFF_MAX_SUP) max_sup_r <= hwdata[15:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tune_set_r <= 4'h0;
      expert_r <= 1'b0;
      expert_r_g <= '0;
      char_r <= CHAR_LINEAR;
      smooth_r <= 16'h0000;
      open_r <= 16'h0000;
      close_r <= 16'h0000;
      igain_r <= 16'h0000;
      idz_r <= 16'h0000;
    end else if (wr) begin
      if (wa == OFF_TUNE) begin
        if (hwdata[3:0] <= TUNE_SET_MAX) tune_set_r <= hwdata[3:0];
        expert_r <= hwdata[TUNE_EXPERT_BIT];
      end
      if (wa == OFF_KP) expert_r_g.kp <= hwdata[15:0];
      if (wa == OFF_KV) expert_r_g.kv <= hwdata[15:0];
      if (wa == OFF_KM) expert_r_g.km <= hwdata[15:0];
      if (wa == OFF_CHAR) char_r <= char_t'(hwdata[1:0]);
      if (wa == OFF_SMOOTH) smooth_r <= hwdata[15:0];
      if (wa == OFF_OPEN) open_r <= hwdata[15:0];
      if (wa == OFF_CLOSE) close_r <= hwdata[15:0];
      if (wa == OFF_IGAIN) igain_r <= hwdata[15:0];
      if (wa == OFF_IDZ) idz_r <= hwdata[15:0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < CURVE_PTS; g++) begin : g_curve
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cv_sp[g] <= 16'(CURVE_STEP * g);
          cv_tv[g] <= 16'(CURVE_STEP * g);
        end else if (wr_cv && wcv == 5'(g)) begin
          cv_sp[g] <= wsp_cl;
          cv_tv[g] <= hwdata[31:16];
        end
      end
    end
  endgenerate

  // read mux, evaluated in the address phase
  logic [15:0] status_w;
  always_comb begin
    rd_w = 32'h0000_0000;
    if (raddr < OFF_DATE) rd_w = id_r[raddr[6:2]];
    else if (raddr == OFF_DATE) rd_w = {8'h00, date_r};
    else if (raddr == OFF_POLL) rd_w = {28'h000_0000, poll_r};
    else if (raddr == OFF_MODE) rd_w = {31'h0000_0000, oos_r};
    else if (raddr == OFF_UNITS) rd_w = {23'h00_0000, units_r};
    else if (raddr == OFF_IN_HI) rd_w = {16'h0000, in_hi_r};
    else if (raddr == OFF_IN_LO) rd_w = {16'h0000, in_lo_r};
    else if (raddr == OFF_MAX_SUP) rd_w = {16'h0000, max_sup_r};
    else if (raddr == OFF_TUNE) rd_w = {23'h00_0000, expert_r, 4'h0, tune_set_r};
    else if (raddr == OFF_KP) rd_w = {16'h0000, expert_r_g.kp};
    else if (raddr == OFF_KV) rd_w = {16'h0000, expert_r_g.kv};
    else if (raddr == OFF_KM) rd_w = {16'h0000, expert_r_g.km};
    else if (raddr == OFF_CHAR) rd_w = {30'h0000_0000, char_r};
    else if (raddr == OFF_SMOOTH) rd_w = {16'h0000, smooth_r};
    else if (raddr == OFF_OPEN) rd_w = {16'h0000, open_r};
    else if (raddr == OFF_CLOSE) rd_w = {16'h0000, close_r};
    else if (raddr == OFF_IGAIN) rd_w = {16'h0000, igain_r};
    else if (raddr == OFF_IDZ) rd_w = {16'h0000, idz_r};
    else if (raddr == OFF_STAT) rd_w = {16'h0000, status_w};
    else if (raddr == OFF_TARGET) rd_w = {16'h0000, travel_target};
    else if (is_curve(raddr)) rd_w = {cv_tv[curve_idx(raddr)], cv_sp[curve_idx(raddr)]};
  end

  // session tag
  wire logic [63:0] tag_now = {id_r[0], id_r[1]};
  logic [63:0] tag_r;
  logic tag_valid_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tag_r <= 64'h0000_0000_0000_0000;
      tag_valid_r <= 1'b0;
    end else if (session_start) begin
      tag_r <= tag_now;
      tag_valid_r <= 1'b1;
    end
  end
  assign session_tag = tag_r;
  assign tag_valid = tag_valid_r;

  // pressure display: hidden above max supply plus a quarter
  wire logic suppr_w = (32'(pressure) * SUPPR_DEN) > (32'(max_sup_r) * SUPPR_NUM);
  logic [15:0] pdisp_r;
  logic pshown_r;
  gains_t gains_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pdisp_r <= 16'h0000;
      pshown_r <= 1'b0;
      gains_r <= '0;
    end else begin
      pdisp_r <= suppr_w ? 16'h0000 : pressure;
      pshown_r <= !suppr_w;
      gains_r <= expert_r ? expert_r_g : tune_gains(tune_set_r);
    end
  end
  assign pressure_display = pdisp_r;
  assign pressure_shown = pshown_r;
  assign gains = gains_r;
  assign pres_unit = pres_unit_t'(units_r[UNIT_PRES_LSB +: 2]);
  assign local_display_unit = pres_unit_t'(units_r[UNIT_DISP_LSB +: 2]);
  assign ai_pct_unit = units_r[UNIT_AI_BIT];
  assign poll_addr = poll_r;

  // ranging: open zero sense inverts the direction
  wire logic zero_open = units_r[UNIT_ZERO_BIT];
  wire logic signed [31:0] span = 32'(in_hi_r) - 32'(in_lo_r);
  wire logic signed [31:0] raw = (span == 0) ? 32'sd0 : ((32'(ai_value) - 32'(in_lo_r)) * 32'(PCT_FULL)) / span;
  wire logic signed [31:0] raw_cl = (raw < 32'(SP_MIN)) ? 32'(SP_MIN) : (raw > 32'(SP_MAX)) ? 32'(SP_MAX) : raw;
  wire logic signed [15:0] ranged = 16'(zero_open ? 32'(PCT_FULL) - raw_cl : raw_cl);

  // characterization
  wire logic signed [31:0] x = 32'(ranged);
  wire logic signed [31:0] sq = (x * x) / 32'(PCT_FULL);
  logic [CURVE_PTS-2:0] seg_hit;
  generate
    for (g = 0; g < CURVE_PTS - 1; g++) begin : g_seg
      assign seg_hit[g] = (ranged >= cv_sp[g]) && (ranged < cv_sp[g+1]);
    end
  endgenerate
  logic signed [31:0] cust;
  always_comb begin
    cust = (ranged >= cv_sp[CURVE_PTS-1]) ? 32'(cv_tv[CURVE_PTS-1]) : 32'(cv_tv[0]);
    for (int i = 0; i < CURVE_PTS - 1; i++) begin
      if (seg_hit[i]) cust = 32'(cv_tv[i]) + ((x - 32'(cv_sp[i])) * (32'(cv_tv[i+1]) - 32'(cv_tv[i])))
                             / (32'(cv_sp[i+1]) - 32'(cv_sp[i]));
    end
  end
  wire logic signed [31:0] char_w = (char_r == CHAR_EQUAL_PCT) ? sq :
                                    (char_r == CHAR_QUICK_OPEN) ? 2 * x - sq :
                                    (char_r == CHAR_CUSTOM) ? cust : x;
  wire logic signed [15:0] char_out = 16'(char_w);

  // processing tick
  logic [31:0] tick_cnt_r;
  wire logic tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tick_cnt_r <= 32'h0000_0000;
    else tick_cnt_r <= tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
  end

  // set point smoothing, first order, fractional state
  logic signed [31:0] filt_r;
  wire logic signed [31:0] char_fx = 32'(char_out) <<< FRAC;
  wire logic signed [31:0] tau_ticks = 32'(smooth_r) * TIME_UNIT_TICKS;
  wire logic signed [31:0] filt_nxt = (smooth_r == 16'h0000) ? char_fx : filt_r + (char_fx - filt_r) / tau_ticks;
  wire logic signed [15:0] filt_out = (smooth_r == 16'h0000) ? char_out : 16'(filt_r >>> FRAC);

  // rate limiting: full range per configured time, spread over ticks
  logic signed [31:0] trav_r;
  wire logic signed [31:0] goal = 32'(filt_out) <<< FRAC;
  wire logic signed [31:0] step_up = (32'(PCT_FULL) <<< FRAC) / (32'(open_r) * TIME_UNIT_TICKS);
  wire logic signed [31:0] step_dn = (32'(PCT_FULL) <<< FRAC) / (32'(close_r) * TIME_UNIT_TICKS);
  wire logic signed [31:0] dlt = goal - trav_r;
  wire logic up_free = (open_r == 16'h0000);
  wire logic dn_free = (close_r == 16'h0000);
  logic signed [31:0] trav_nxt;
  always_comb begin
    trav_nxt = trav_r;
    if (dlt > 0) begin
      if (up_free || (tick && dlt <= step_up)) trav_nxt = goal;
      else if (tick) trav_nxt = trav_r + step_up;
    end else if (dlt < 0) begin
      if (dn_free || (tick && -dlt <= step_dn)) trav_nxt = goal;
      else if (tick) trav_nxt = trav_r - step_dn;
    end
  end

  // integrator gating
  wire logic signed [31:0] err = 32'(travel_target) - 32'(actual_travel);
  wire logic [31:0] abs_err = (err < 0) ? 32'(-err) : 32'(err);
  wire logic integ_en = (igain_r != 16'h0000) && (abs_err >= 32'(idz_r));
  logic signed [31:0] integ_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filt_r <= 32'sh0000_0000;
      trav_r <= 32'sh0000_0000;
      integ_r <= 32'sh0000_0000;
    end else begin
      if (tick || smooth_r == 16'h0000) filt_r <= filt_nxt;
      trav_r <= trav_nxt;
      if (tick && integ_en) integ_r <= integ_r + ((err * $signed(32'(igain_r))) >>> FRAC);
    end
  end

  assign travel_target = 16'(trav_r >>> FRAC);
  assign integ_value = integ_r;
  assign integ_active = integ_en;
  assign status_w = 16'({suppr_w, integ_en, refused_r});

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_up_limited;
    tick && !up_free && (dlt > step_up);
  endsequence
  sequence s_dn_limited;
    tick && !dn_free && (-dlt > step_dn);
  endsequence

  a_tag_shown: assert property (session_start |=> tag_valid && session_tag == $past(tag_now))
    else $error("tag not presented at session start");
  a_poll_range: assert property (wr_poll && (hwdata > 32'(POLL_MAX)) |=> $stable(poll_addr) && refused_r)
    else $error("polling address above limit accepted");
  a_poll_locked: assert property (!oos_r |=> $stable(poll_addr))
    else $error("polling address changed in service");
  a_zero_sense: assert property ((ai_value == in_lo_r && in_hi_r > in_lo_r) |->
    ranged == (zero_open ? PCT_FULL : 16'sh0000)) else $error("zero input ranged wrongly");
  a_display_hidden: assert property (suppr_w |=> !pressure_shown && pressure_display == 16'h0000)
    else $error("pressure shown above limit");
  a_expert_gains: assert property (expert_r ##1 expert_r |-> gains == $past(expert_r_g))
    else $error("expert gains not applied");
  a_curve_range: assert property (wr_cv |=> cv_sp[$past(wcv)] >= SP_MIN && cv_sp[$past(wcv)] <= SP_MAX)
    else $error("breakpoint set point out of range");
  a_filter_bypass: assert property ((smooth_r == 16'h0000 && up_free && dn_free) |=> trav_r == $past(char_fx))
    else $error("filter not bypassed");
  a_open_rate: assert property (s_up_limited |=> trav_r == $past(trav_r) + $past(step_up))
    else $error("opening step wrong");
  a_close_rate: assert property (s_dn_limited |=> trav_r == $past(trav_r) - $past(step_dn))
    else $error("closing step wrong");
  a_gain_zero: assert property (igain_r == 16'h0000 |-> !integ_active)
    else $error("integrator active with zero gain");
  a_dead_zone: assert property (abs_err < 32'(idz_r) |-> !integ_active)
    else $error("integrator active in dead zone");
  a_integ_hold: assert property (!integ_en |=> $stable(integ_value))
    else $error("integrator moved while disabled");
endmodule // valve_setpoint_processing

// [verilog/valve_pkg.sv]
/*
  constants, types and register map of the valve set point processing block.
  assumes a 100 MHz system clock and a 1 ms processing tick.
*/
package valve_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1_000_000;
  localparam int TICK_CYCLES_DFLT = TICK_PERIOD_NS / CLK_PERIOD_NS;
  // time settings count in tenths of a second
  localparam int TIME_UNIT_NS = 100_000_000;
  localparam int TIME_UNIT_TICKS = TIME_UNIT_NS / TICK_PERIOD_NS;
  localparam int FRAC = 8;

  // byte offsets
  localparam logic [11:0] OFF_ID = 12'h000;
  localparam logic [11:0] OFF_DATE = 12'h050;
  localparam logic [11:0] OFF_POLL = 12'h054;
  localparam logic [11:0] OFF_MODE = 12'h058;
  localparam logic [11:0] OFF_UNITS = 12'h05C;
  localparam logic [11:0] OFF_IN_HI = 12'h060;
  localparam logic [11:0] OFF_IN_LO = 12'h064;
  localparam logic [11:0] OFF_MAX_SUP = 12'h068;
  localparam logic [11:0] OFF_TUNE = 12'h06C;
  localparam logic [11:0] OFF_KP = 12'h070;
  localparam logic [11:0] OFF_KV = 12'h074;
  localparam logic [11:0] OFF_KM = 12'h078;
  localparam logic [11:0] OFF_CHAR = 12'h07C;
  localparam logic [11:0] OFF_SMOOTH = 12'h080;
  localparam logic [11:0] OFF_OPEN = 12'h084;
  localparam logic [11:0] OFF_CLOSE = 12'h088;
  localparam logic [11:0] OFF_IGAIN = 12'h08C;
  localparam logic [11:0] OFF_IDZ = 12'h090;
  localparam logic [11:0] OFF_STAT = 12'h094;
  localparam logic [11:0] OFF_TARGET = 12'h098;
  localparam logic [11:0] OFF_CURVE = 12'h100;

  // identification words: tag 0-1, message 2-9, descriptor 10-13, valve serial 14-16, instrument serial 17-19
  localparam int ID_WORDS = 20;
  localparam int CURVE_PTS = 21;

  // field positions
  localparam int UNIT_AI_BIT = 0;
  localparam int UNIT_PRES_LSB = 2;
  localparam int UNIT_DISP_LSB = 4;
  localparam int UNIT_ZERO_BIT = 8;
  localparam int TUNE_EXPERT_BIT = 8;
  localparam int STAT_REFUSED_BIT = 0;
  localparam int STAT_INTEG_BIT = 1;
  localparam int STAT_SUPPR_BIT = 2;

  // percent scale: 2000 counts per 100 %
  localparam logic signed [15:0] PCT_FULL = 16'sh07D0;
  localparam logic signed [15:0] SP_MIN = 16'shFF83;
  localparam logic signed [15:0] SP_MAX = 16'sh084D;
  localparam logic signed [15:0] CURVE_STEP = 16'sh0064;
  localparam logic [3:0] POLL_MAX = 4'hF;
  localparam logic [3:0] TUNE_SET_MAX = 4'hA;
  localparam int SUPPR_NUM = 5;
  localparam int SUPPR_DEN = 4;

  // preselected gains, index 0 is the slowest set
  localparam logic [15:0] KP_BASE = 16'h0010;
  localparam logic [15:0] KP_STEP = 16'h0004;
  localparam logic [15:0] KV_BASE = 16'h0020;
  localparam logic [15:0] KV_STEP = 16'h0008;
  localparam logic [15:0] KM_BASE = 16'h0008;
  localparam logic [15:0] KM_STEP = 16'h0002;

  typedef enum logic [1:0] {CHAR_LINEAR, CHAR_EQUAL_PCT, CHAR_QUICK_OPEN, CHAR_CUSTOM} char_t;
  typedef enum logic [1:0] {PRES_PSI, PRES_BAR, PRES_KPA, PRES_NONE} pres_unit_t;

  typedef struct packed {
    logic [15:0] kp;
    logic [15:0] kv;
    logic [15:0] km;
  } gains_t;

  typedef struct packed {
    logic [11:0] addr;
    logic write;
    logic valid;
  } ahb_req_t;
endpackage

// [tb/valve_host_model.sv]
/*
  bus host model: issues single word AHB-Lite transfers for the bench.
  assumes hready is the slave's hreadyout and the slave always answers OKAY.
*/
`timescale 1ns/10ps
module valve_host_model (
  // clock
  input wire logic hclk,
  // master side
  output logic hsel = 1'b0,
  output logic [31:0] haddr = 32'h0000_0000,
  output logic [1:0] htrans = 2'b00,
  output logic hwrite = 1'b0,
  output logic [2:0] hsize = 3'b010,
  output logic [31:0] hwdata = 32'h0000_0000,
  // slave answer and hang flag
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hang = 1'b0
);
  // called just after a rising edge; each phase is held until hready is sampled high
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {20'h0_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= w ? d : ~hwdata;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    r = hrdata;
    // stale write data must not look valid outside its phase
    hwdata <= ~d;
    if (n >= 100) hang <= 1'b1;
  endtask
endmodule // valve_host_model

// [tb/valve_setpoint_processing_bench.sv]
/*
  self-checking bench of the valve set point block with the host model on its bus.
  assumes zero wait states and a shortened tick of 10 clocks.
*/
`timescale 1ns/10ps
module valve_setpoint_processing_bench;
  import valve_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, hang, session_start;
  logic tag_valid, pressure_shown, ai_pct_unit, integ_active;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic signed [15:0] ai_value, actual_travel, travel_target;
  logic [15:0] pressure, pressure_display;
  logic [63:0] session_tag;
  logic [3:0] poll_addr;
  logic signed [31:0] integ_value;
  pres_unit_t pres_unit, local_display_unit;
  gains_t gains;
  int errors, total_checks;

  valve_host_model host (.hclk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hang);
  valve_setpoint_processing #(.TICK_CYCLES(10)) DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .session_start, .ai_value, .actual_travel, .pressure,
    .session_tag, .tag_valid, .pressure_display, .pressure_shown, .pres_unit, .local_display_unit, .ai_pct_unit,
    .gains, .poll_addr, .travel_target, .integ_value, .integ_active);

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(a, 1'b1, d, q);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    host.xfer(a, 1'b0, 32'h0000_0000, q);
    chk(q, e);
    chk(hresp, 1'b0);
  endtask

  task automatic wait_tt(input logic signed [15:0] e, input int lim);
    int n;
    for (n = 0; n < lim && travel_target !== e; n++) @(posedge hclk);
    chk(travel_target, e);
    if (n >= lim) give_verdict();
  endtask

  function automatic logic signed [15:0] shape(input int m, input int x);
    case (m)
      1: return 16'(x * x / 2000);
      2: return 16'(2 * x - x * x / 2000);
      default: return 16'(x);
    endcase
  endfunction

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  always @(posedge hang) begin
    errors++;
    give_verdict();
  end

  initial begin
    int s;
    logic [31:0] id [20];
    logic [47:0] g;
    logic signed [31:0] v;
    errors = 0;
    total_checks = 0;
    hresetn = 1'b0;
    session_start = 1'b0;
    ai_value = 16'sh0000;
    actual_travel = 16'sh0000;
    pressure = 16'h0000;
    void'($urandom(32'h7cac2610));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({tag_valid, poll_addr}, 5'h00);
    rd(OFF_IN_HI, 32'h0000_07D0);
    rd(OFF_MAX_SUP, 32'h0000_FFFF);
    rd(12'h09C, 32'h0000_0000);
    for (s = 0; s < 21; s++) rd(12'(OFF_CURVE + 4 * s), {16'(100 * s), 16'(100 * s)});
    $display("reset values done");
    for (s = 0; s < 20; s++) begin
      id[s] = $urandom;
      wr(12'(4 * s), id[s]);
    end
    for (s = 0; s < 20; s++) rd(12'(4 * s), id[s]);
    wr(OFF_DATE, 32'h0012_3125);
    rd(OFF_DATE, 32'h0012_3125);
    session_start <= 1'b1;
    @(posedge hclk);
    session_start <= 1'b0;
    @(posedge hclk);
    chk({tag_valid, session_tag}, {1'b1, id[0], id[1]});
    $display("identification done");
    // address changes are refused while in service
    wr(OFF_POLL, 32'h0000_0005);
    rd(OFF_STAT, 32'h0000_0001);
    chk(poll_addr, 4'h0);
    wr(OFF_STAT, 32'h0000_0001);
    wr(OFF_MODE, 32'h0000_0001);
    wr(OFF_POLL, 32'h0000_0010);
    rd(OFF_STAT, 32'h0000_0001);
    wr(OFF_STAT, 32'h0000_0001);
    g = 48'($urandom_range(15));
    for (s = 0; s < 2; s++) begin
      wr(OFF_POLL, s ? 32'h0000_000F : g[31:0]);
      @(posedge hclk);
      chk(poll_addr, s ? 4'hF : g[3:0]);
    end
    $display("polling address done");
    for (s = 0; s < 3; s++) begin
      wr(OFF_UNITS, 32'((s << 2) | ((2 - s) << 4) | (s & 1)));
      repeat (2) @(posedge hclk);
      chk({ai_pct_unit, pres_unit, local_display_unit}, {1'(s & 1), 2'(s), 2'(2 - s)});
    end
    wr(OFF_UNITS, 32'h0000_003C);
    repeat (2) @(posedge hclk);
    chk({pres_unit, local_display_unit}, 4'h8);
    wr(OFF_MAX_SUP, 32'h0000_0190);
    pressure <= 16'h01F4;
    repeat (2) @(posedge hclk);
    chk({pressure_shown, pressure_display}, 17'h1_01F4);
    pressure <= 16'h01F5;
    repeat (2) @(posedge hclk);
    chk({pressure_shown, pressure_display}, 17'h0_0000);
    pressure <= 16'h0000;
    $display("units and pressure done");
    for (s = 0; s < 11; s++) begin
      wr(OFF_TUNE, 32'(s));
      repeat (2) @(posedge hclk);
      chk(gains, {16'(16 + 4 * s), 16'(32 + 8 * s), 16'(8 + 2 * s)});
    end
    // a set number above the last set is ignored
    wr(OFF_TUNE, 32'h0000_000F);
    repeat (2) @(posedge hclk);
    chk(gains, {16'd56, 16'd112, 16'd28});
    g = 48'({$urandom, $urandom});
    wr(OFF_KP, {16'h0000, g[47:32]});
    wr(OFF_KV, {16'h0000, g[31:16]});
    wr(OFF_KM, {16'h0000, g[15:0]});
    wr(OFF_TUNE, 32'h0000_0100);
    repeat (2) @(posedge hclk);
    chk(gains, g);
    $display("tuning done");
    wr(OFF_UNITS, 32'h0000_0000);
    wait_tt(16'sd0, 40);
    wr(OFF_UNITS, 32'h0000_0100);
    wait_tt(16'sd2000, 40);
    ai_value <= 16'sd2000;
    wait_tt(16'sd0, 40);
    wr(OFF_UNITS, 32'h0000_0000);
    ai_value <= 16'sd1000;
    for (s = 0; s < 3; s++) begin
      wr(OFF_CHAR, 32'(s));
      wait_tt(shape(s, 1000), 40);
    end
    wr(12'(OFF_CURVE + 40), {16'd1600, 16'd1000});
    wr(OFF_CHAR, 32'h0000_0003);
    wait_tt(16'sd1600, 40);
    wr(OFF_CURVE, 32'h0000_8000);
    rd(OFF_CURVE, 32'h0000_FF83);
    wr(OFF_CHAR, 32'h0000_0000);
    wait_tt(16'sd1000, 40);
    wr(OFF_IN_LO, 32'h0000_0190);
    ai_value <= 16'sd1600;
    wait_tt(16'sd1500, 40);
    wr(OFF_IN_LO, 32'h0000_0000);
    ai_value <= 16'sd1000;
    wait_tt(16'sd1000, 40);
    $display("characterization done");
    // 0.1 s over 100 ticks of 10 clocks allows 20 counts per tick
    wr(OFF_OPEN, 32'h0000_0001);
    ai_value <= 16'sd2000;
    repeat (200) @(posedge hclk);
    chk(travel_target > 16'sd1000 && travel_target < 16'sd2000, 1'b1);
    wait_tt(16'sd2000, 1200);
    ai_value <= 16'sd0;
    wait_tt(16'sd0, 20);
    wr(OFF_OPEN, 32'h0000_0000);
    ai_value <= 16'sd2000;
    wait_tt(16'sd2000, 20);
    wr(OFF_CLOSE, 32'h0000_0001);
    ai_value <= 16'sd0;
    repeat (200) @(posedge hclk);
    chk(travel_target > 16'sd0 && travel_target < 16'sd2000, 1'b1);
    wait_tt(16'sd0, 1200);
    wr(OFF_CLOSE, 32'h0000_0000);
    wr(OFF_SMOOTH, 32'h0000_0001);
    ai_value <= 16'sd2000;
    repeat (100) @(posedge hclk);
    chk(travel_target > 16'sd0 && travel_target < 16'sd2000, 1'b1);
    wr(OFF_SMOOTH, 32'h0000_0000);
    wait_tt(16'sd2000, 40);
    $display("rate and filter done");
    wr(OFF_IDZ, 32'h0000_0064);
    @(posedge hclk);
    chk(integ_active, 1'b0);
    wr(OFF_IGAIN, 32'h0000_0100);
    @(posedge hclk);
    chk(integ_active, 1'b1);
    rd(OFF_STAT, 32'h0000_0002);
    repeat (30) @(posedge hclk);
    chk(integ_value != 32'sd0, 1'b1);
    actual_travel <= 16'sd1950;
    repeat (2) @(posedge hclk);
    chk(integ_active, 1'b0);
    v = integ_value;
    repeat (30) @(posedge hclk);
    chk(integ_value, v);
    actual_travel <= 16'sd1900;
    repeat (2) @(posedge hclk);
    chk(integ_active, 1'b1);
    $display("integrator done");
    give_verdict();
  end
endmodule // valve_setpoint_processing_bench
